// File: rtl/cam_counter_array.sv
module cam_counter_array (
    input wire logic ref_clk_i,                // system clock
    input wire logic reset_n_i,                // async reset, active low
    input wire logic [7:0] s_axi_awaddr_i,     // write address
    input wire logic s_axi_awvalid_i,          // write address valid
    output logic s_axi_awready_o,              // write address ready
    input wire logic [31:0] s_axi_wdata_i,     // write data
    input wire logic [3:0] s_axi_wstrb_i,      // write strobes
    input wire logic s_axi_wvalid_i,           // write data valid
    output logic s_axi_wready_o,               // write data ready
    output logic [1:0] s_axi_bresp_o,          // write response
    output logic s_axi_bvalid_o,               // write response valid
    input wire logic s_axi_bready_i,           // write response ready
    input wire logic [7:0] s_axi_araddr_i,     // read address
    input wire logic s_axi_arvalid_i,          // read address valid
    output logic s_axi_arready_o,              // read address ready
    output logic [31:0] s_axi_rdata_o,         // read data
    output logic [1:0] s_axi_rresp_o,          // read response
    output logic s_axi_rvalid_o,               // read data valid
    input wire logic s_axi_rready_i,           // read data ready
    input wire logic [7:0] module_pin_i,       // capture inputs, async
    output logic [7:0] module_pin_o,           // waveform outputs
    output logic [7:0] module_pin_oe_o,        // pin driven by module
    output logic [7:0] module_irq_o,           // per-module interrupt request
    input wire logic timer_zero_overflow_i,    // step source pulse
    input wire logic timer_one_overflow_i,     // step source pulse
    input wire logic timer_three_overflow_i,   // step source pulse
    input wire logic serial_zero_baud_overflow_i // step source pulse
);
    // ***********************************************
    // state
    // ***********************************************
    logic [15:0] cnt_ff;
    logic [7:0] mode_ff [8];
    logic [7:0] cl_ff [8];
    logic [7:0] ch_ff [8];
    logic [7:0] aux_ff [8];
    logic [16:0] act_ff [8];
    logic [7:0] flag_ff, wave_ff, pin_ff, oe_ff, irq_ff;
    logic [7:0] sync1_ff, sync2_ff, prev_ff;
    logic [2:0] pair_ff;
    logic [7:0] aux9_ff;
    logic awready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;

    // resolution to counter mask
    function automatic logic [15:0] res_mask(input logic [1:0] res);
        logic [15:0] m;
        m = 16'h00FF;
        case (res)
            cam_pkg::CAM_RES10: m = 16'h03FF;
            cam_pkg::CAM_RES12: m = 16'h0FFF;
            cam_pkg::CAM_RES16: m = 16'hFFFF;
            default: m = 16'h00FF;
        endcase
        return m;
    endfunction

    // ***********************************************
    // bus decode
    // ***********************************************
    wire wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~awready_ff & ~bvalid_ff;
    wire rd_go = s_axi_arvalid_i & ~arready_ff & ~rvalid_ff;
    wire [7:0] wa = s_axi_awaddr_i;
    wire [7:0] ra = s_axi_araddr_i;
    wire [7:0] wd = s_axi_wdata_i[7:0];
    wire wr_b0 = wr_go & s_axi_wstrb_i[0];
    wire wr_mod = wr_b0 & (wa < cam_pkg::MOD_SPAN);
    wire wr_flags = wr_b0 & (wa == cam_pkg::OFF_FLAGS);
    wire wr_pair = wr_b0 & (wa == cam_pkg::OFF_PAIR);
    wire wr_aux9 = wr_b0 & (wa == cam_pkg::OFF_AUX9);
    wire wa_ok = (wa < cam_pkg::MOD_SPAN) | (wa == cam_pkg::OFF_COUNT) | (wa == cam_pkg::OFF_FLAGS)
        | (wa == cam_pkg::OFF_PAIR) | (wa == cam_pkg::OFF_AUX9);

    // read mux
    logic [7:0] rd_byte;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        rd_byte = 8'h00;
        if (ra < cam_pkg::MOD_SPAN) begin
            if (ra[3:2] == cam_pkg::SEL_MODE) rd_byte = mode_ff[ra[6:4]];
            else if (ra[3:2] == cam_pkg::SEL_CMPL) rd_byte = cl_ff[ra[6:4]];
            else if (ra[3:2] == cam_pkg::SEL_CMPH) rd_byte = ch_ff[ra[6:4]];
            else rd_byte = aux_ff[ra[6:4]] | {4'h0, flag_ff[ra[6:4]], 3'h0};
        end else if (ra == cam_pkg::OFF_FLAGS) rd_byte = flag_ff;
        else if (ra == cam_pkg::OFF_PAIR) rd_byte = {5'h00, pair_ff};
        else if (ra == cam_pkg::OFF_AUX9) rd_byte = aux9_ff;
        else if (ra != cam_pkg::OFF_COUNT) rd_ok = 1'b0;
    end
    wire [31:0] rd_word = (ra == cam_pkg::OFF_COUNT) ? {16'h0000, cnt_ff} : {24'h000000, rd_byte};

    // ***********************************************
    // capture edges and step event
    // ***********************************************
    wire [7:0] rise_edge = sync2_ff & ~prev_ff;
    wire [7:0] fall_edge = ~sync2_ff & prev_ff;
    wire [1:0] step_sel = aux9_ff[cam_pkg::B_STEP_HI:cam_pkg::B_STEP_LO];
    // step source pick
    wire step = (step_sel == 2'b00) ? timer_zero_overflow_i :
                (step_sel == 2'b01) ? timer_one_overflow_i :
                (step_sel == 2'b10) ? timer_three_overflow_i : serial_zero_baud_overflow_i;
    // pair enables; 6/7 from module 6 mode bit 7
    wire [3:0] pair_on = {mode_ff[6][cam_pkg::B_PAIR6], pair_ff};

    // ***********************************************
    // per-module decode
    // ***********************************************
    wire [7:0] cap_go, fifo_on, pwm_on, compare_on_pwm_match_on, hso_on, m16, pm, lvl, ovf, buf_on, set_ev;
    wire [7:0] nxt_cl [8];
    wire [7:0] nxt_ch [8];
    wire [16:0] reload [8];
    wire [16:0] cmp [8];
    logic [7:0] nxt_wave;
    genvar g;
    for (g = 0; g < 8; g++) begin : gm
        wire [7:0] md = mode_ff[g];
        wire [1:0] res = aux_ff[g][cam_pkg::B_RES_HI:cam_pkg::B_RES_LO];
        wire [15:0] mask = res_mask(res);
        wire [15:0] cnt_m = cnt_ff & mask; // shared counter
        wire ecom = md[cam_pkg::B_ECOM];
        wire rise = (g < 6) & md[cam_pkg::B_RISE];
        wire fall = md[cam_pkg::B_FALL];
        wire mat = md[cam_pkg::B_MAT];
        wire tog = md[cam_pkg::B_TOG];
        wire pwm = md[cam_pkg::B_PWM];
        wire own_wr = wr_mod & (wa[6:4] == 3'(g));
        wire partner_cap;
        wire fifo_prev;
        // capture qualifier, modules 6/7 excluded
        assign cap_go[g] = (g < 6) & ~mat & ~tog & ~pwm
            & ((rise & rise_edge[g]) | (fall & fall_edge[g]));
        assign pwm_on[g] = pwm & ecom;
        assign fifo_on[g] = (g < 7) & pwm_on[g] & fall & ~mat & ~tog;
        assign compare_on_pwm_match_on[g] = pwm_on[g] & tog & ~mat & ~fall;
        assign hso_on[g] = ecom & mat & tog & ~pwm & ~rise & ~fall;
        assign m16[g] = ecom & ~pwm & (cnt_ff == {ch_ff[g], cl_ff[g]});
        assign buf_on[g] = (res == cam_pkg::CAM_RES8) | pair_on[g/2];
        // 8-bit uses {ext_h, high}; high resolution whole word
        assign reload[g] = (res == cam_pkg::CAM_RES8) ? {8'h00, aux_ff[g][cam_pkg::B_EXT_H], ch_ff[g]}
            : {aux_ff[g][cam_pkg::B_EXT_H], ch_ff[g], cl_ff[g]};
        // unbuffered takes bytes as written
        assign cmp[g] = buf_on[g] ? act_ff[g] : {1'b0, {ch_ff[g], cl_ff[g]} & mask};
        assign ovf[g] = (cnt_m == mask);
        assign lvl[g] = ({1'b0, cnt_m} >= cmp[g]);
        assign pm[g] = pwm_on[g] & ({1'b0, cnt_m} == cmp[g]);
        assign set_ev[g] = cap_go[g] | (mat & m16[g]) | (pwm_on[g] & mat & pm[g]);
        // odd module buffers the even partner's capture
        if (g % 2 == 1 && g < 6) begin : godd
            assign partner_cap = cap_go[g-1] & pair_on[g/2];
        end else begin : geven
            assign partner_cap = 1'b0;
        end
        if (g > 0) begin : gprev
            assign fifo_prev = fifo_on[g-1];
        end else begin : gfirst
            assign fifo_prev = 1'b0;
        end
        // byte chain: ch[n] <- cl[n+1] <- ch[n+1] <- ch[n]
        if (g < 7) begin : gch
            assign nxt_ch[g] = cap_go[g] ? cnt_ff[15:8] : partner_cap ? ch_ff[g-(g%2)]
                : (fifo_on[g] & step) ? cl_ff[g+1] : (fifo_prev & step) ? ch_ff[(g > 0) ? g - 1 : 0]
                : (own_wr & wa[3:2] == cam_pkg::SEL_CMPH) ? wd : ch_ff[g];
        end else begin : gch7
            assign nxt_ch[g] = (fifo_prev & step) ? ch_ff[g-1]
                : (own_wr & wa[3:2] == cam_pkg::SEL_CMPH) ? wd : ch_ff[g];
        end
        assign nxt_cl[g] = cap_go[g] ? cnt_ff[7:0] : partner_cap ? cl_ff[g-(g%2)]
            : (fifo_prev & step) ? ch_ff[g]
            : (own_wr & wa[3:2] == cam_pkg::SEL_CMPL) ? wd : cl_ff[g];
        // waveform: pair start/end edges, toggles, plain pwm level
        if (g % 2 == 0 && g < 6) begin : gpair
            always_comb begin
                nxt_wave[g] = wave_ff[g];
                if (compare_on_pwm_match_on[g] & pair_on[g/2]) begin
                    if (pm[g]) nxt_wave[g] = 1'b1;
                    else if (pm[g+1]) nxt_wave[g] = 1'b0;
                end else if (compare_on_pwm_match_on[g]) begin
                    if (pm[g]) nxt_wave[g] = ~wave_ff[g];
                end else if (pwm_on[g]) nxt_wave[g] = lvl[g];
                else if (hso_on[g] & m16[g]) nxt_wave[g] = ~wave_ff[g];
            end
        end else begin : gsolo
            always_comb begin
                nxt_wave[g] = wave_ff[g];
                if (compare_on_pwm_match_on[g]) begin
                    if (pm[g]) nxt_wave[g] = ~wave_ff[g];
                end else if (pwm_on[g]) nxt_wave[g] = lvl[g];
                else if (hso_on[g] & m16[g]) nxt_wave[g] = ~wave_ff[g];
            end
        end
    end

    // flags: set wins over software zero write
    logic [7:0] keep_mask;
    always_comb begin
        keep_mask = 8'hFF;
        if (wr_flags) keep_mask = wd;
        for (int i = 0; i < 8; i++) begin
            if (wr_mod & (wa[6:4] == 3'(i)) & (wa[3:2] == cam_pkg::SEL_AUX) & ~wd[cam_pkg::B_FLAG])
                keep_mask[i] = 1'b0;
        end
    end
    wire [7:0] nxt_flag = (flag_ff & keep_mask) | set_ev;

    // ***********************************************
    // pin sync, counter, flags, outputs
    // ***********************************************
    // no dead-time, break or central alignment path exists
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
            prev_ff <= 8'h00;
            cnt_ff <= cam_pkg::RST_COUNT;
            flag_ff <= 8'h00;
            wave_ff <= 8'h00;
            pin_ff <= 8'h00;
            oe_ff <= 8'h00;
            irq_ff <= 8'h00;
            pair_ff <= 3'h0;
            aux9_ff <= cam_pkg::RST_BYTE;
        end else begin
            sync1_ff <= module_pin_i;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
            cnt_ff <= cnt_ff + 16'h0001;
            flag_ff <= nxt_flag;
            wave_ff <= nxt_wave;
            irq_ff <= nxt_flag & {mode_ff[7][0], mode_ff[6][0], mode_ff[5][0], mode_ff[4][0],
                mode_ff[3][0], mode_ff[2][0], mode_ff[1][0], mode_ff[0][0]};
            for (int i = 0; i < 8; i++) begin
                pin_ff[i] <= nxt_wave[i] ^ aux_ff[i][cam_pkg::B_INV];
                oe_ff[i] <= mode_ff[i][cam_pkg::B_PWM] | mode_ff[i][cam_pkg::B_TOG];
            end
            if (wr_pair) pair_ff <= wd[2:0];
            if (wr_aux9) aux9_ff <= wd & cam_pkg::AUX9_WMASK;
        end
    end

    // module registers and active compare reload
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 8; i++) begin
                mode_ff[i] <= cam_pkg::RST_BYTE;
                cl_ff[i] <= cam_pkg::RST_BYTE;
                ch_ff[i] <= cam_pkg::RST_BYTE;
                aux_ff[i] <= cam_pkg::RST_BYTE;
                act_ff[i] <= 17'h00000;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                cl_ff[i] <= nxt_cl[i];
                ch_ff[i] <= nxt_ch[i];
                if (pwm_on[i] & ovf[i]) act_ff[i] <= reload[i];
                if (wr_mod & (wa[6:4] == 3'(i))) begin
                    if (wa[3:2] == cam_pkg::SEL_MODE)
                        mode_ff[i] <= (i >= 6) ? (wd & ((i == 6) ? 8'hDF : 8'h5F)) : wd;
                    if (wa[3:2] == cam_pkg::SEL_AUX) aux_ff[i] <= wd & cam_pkg::AUX_WMASK;
                end
            end
        end
    end

    // ***********************************************
    // axi4-lite handshake
    // ***********************************************
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            awready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= cam_pkg::RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rresp_ff <= cam_pkg::RESP_OKAY;
            rdata_ff <= 32'h00000000;
        end else begin
            awready_ff <= wr_go;
            if (wr_go) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wa_ok ? cam_pkg::RESP_OKAY : cam_pkg::RESP_SLVERR;
            end else if (s_axi_bready_i) bvalid_ff <= 1'b0;
            arready_ff <= rd_go;
            if (rd_go) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_ok ? rd_word : 32'h00000000;
                rresp_ff <= rd_ok ? cam_pkg::RESP_OKAY : cam_pkg::RESP_SLVERR;
            end else if (s_axi_rready_i) rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_awready_o = awready_ff;
    assign s_axi_wready_o = awready_ff;
    assign s_axi_bvalid_o = bvalid_ff;
    assign s_axi_bresp_o = bresp_ff;
    assign s_axi_arready_o = arready_ff;
    assign s_axi_rvalid_o = rvalid_ff;
    assign s_axi_rresp_o = rresp_ff;
    assign s_axi_rdata_o = rdata_ff;
    assign module_pin_o = pin_ff;
    assign module_pin_oe_o = oe_ff;
    assign module_irq_o = irq_ff;

    // ***********************************************
    // assertions
    // ***********************************************
    a_capture_load: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        cap_go[0] |=> (cl_ff[0] == $past(cnt_ff[7:0])) && (ch_ff[0] == $past(cnt_ff[15:8])) && flag_ff[0])
        else $error("capture did not load counter");
    a_no_cap_hi: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        cap_go[7:6] == 2'b00) else $error("capture on module 6 or 7");
    a_irq_gate: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        ##1 module_irq_o[1] == (flag_ff[1] & $past(mode_ff[1][0]))) else $error("irq not gated by flag");
    a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (flag_ff[1] && !wr_go) |=> flag_ff[1]) else $error("flag cleared without write");
    a_buf_capture: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (cap_go[0] && pair_on[0]) |=> cl_ff[1] == $past(cl_ff[0])) else $error("pair buffer not shifted");
    a_hso_toggle: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (hso_on[3] && m16[3]) |=> module_pin_o[3] != $past(module_pin_o[3])) else $error("no toggle on match");
    a_pwm_level: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (pwm_on[2] && !compare_on_pwm_match_on[2] && !fifo_on[2]) |=> wave_ff[2] == $past(lvl[2])) else $error("pwm level wrong");
    a_pwm_reload: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (pwm_on[2] && ovf[2]) |=> act_ff[2] == $past(reload[2])) else $error("compare not reloaded");
    a_fifo_step: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (fifo_on[0] && step && !cap_go[0]) |=> ch_ff[0] == $past(cl_ff[1])) else $error("fifo did not step");
    // counter check waits one edge after release, the first edge still sees reset
    a_counter_run: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        $past(reset_n_i) |-> cnt_ff == $past(cnt_ff) + 16'h0001) else $error("shared counter stalled");
    a_no_rise_hi: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        !mode_ff[6][cam_pkg::B_RISE] && !mode_ff[7][cam_pkg::B_RISE]) else $error("rise bit kept on module 6 or 7");
    // buffered pair edges: even match starts the pulse, odd match ends it
    a_pair_start: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (compare_on_pwm_match_on[0] && pair_on[0] && pm[0]) |=> wave_ff[0]) else $error("pair pulse did not start");
    a_pair_end: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (compare_on_pwm_match_on[0] && pair_on[0] && pm[1] && !pm[0]) |=> !wave_ff[0]) else $error("pair pulse did not end");
    // fifo tail byte and 8-bit wrap point
    a_fifo_tail: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (fifo_on[0] && step && !cap_go[1]) |=> ch_ff[1] == $past(ch_ff[0])) else $error("fifo tail not moved");
    a_res_wrap: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (aux_ff[2][7:6] == cam_pkg::CAM_RES8) |-> ovf[2] == (cnt_ff[7:0] == 8'hFF)) else $error("wrong wrap point");
endmodule

// File: common/cam_pkg.sv
package cam_pkg;
    // ***********************************************
    // register byte offsets
    // ***********************************************
    localparam logic [7:0] MOD_SPAN = 8'h80;      // module blocks below this
    localparam logic [1:0] SEL_MODE = 2'h0;       // module_mode_register
    localparam logic [1:0] SEL_CMPL = 2'h1;       // compare_low
    localparam logic [1:0] SEL_CMPH = 2'h2;       // compare_high
    localparam logic [1:0] SEL_AUX = 2'h3;        // pwm_aux_register
    localparam logic [7:0] OFF_COUNT = 8'h80;     // shared counter, read only
    localparam logic [7:0] OFF_FLAGS = 8'h84;     // event flags, write 0 clears
    localparam logic [7:0] OFF_PAIR = 8'h88;      // pair buffer enables 0/2/4
    localparam logic [7:0] OFF_AUX9 = 8'hA4;      // auxiliary_control_nine
    // ***********************************************
    // mode register fields
    // ***********************************************
    localparam int B_PAIR6 = 7;
    localparam int B_ECOM = 6;
    localparam int B_RISE = 5;
    localparam int B_FALL = 4;
    localparam int B_MAT = 3;
    localparam int B_TOG = 2;
    localparam int B_PWM = 1;
    localparam int B_IRQ = 0;
    // ***********************************************
    // pwm aux fields
    // ***********************************************
    localparam int B_RES_HI = 7;
    localparam int B_RES_LO = 6;
    localparam int B_FLAG = 3;
    localparam int B_INV = 2;
    localparam int B_EXT_H = 1;
    localparam int B_EXT_L = 0;
    localparam logic [7:0] AUX_WMASK = 8'hC7;     // reserved bits read zero
    localparam logic [7:0] AUX9_WMASK = 8'h3F;
    localparam int B_STEP_HI = 3;
    localparam int B_STEP_LO = 2;
    // ***********************************************
    // reset values and bus answers
    // ***********************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        CAM_RES8 = 2'b00,
        CAM_RES10 = 2'b01,
        CAM_RES12 = 2'b10,
        CAM_RES16 = 2'b11
    } cam_res_type;
endpackage

// File: verif/cam_pin_model.sv
// far side of the capture pins; levels change clear of the sampling edge
module cam_pin_model (
    input wire logic ref_clk_i,     // system clock
    input wire logic [7:0] level_i, // requested pin levels
    output logic [7:0] pin_o        // capture inputs to the block
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pin_o = 8'h00;
    // pins move 5 ns after the edge, as a real source would
    always @(posedge ref_clk_i) begin
        pin_o <= #5 level_i;
    end
endmodule

// File: verif/cam_counter_array_bench.sv
module cam_counter_array_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00, pin_req = 8'h00;
    logic [31:0] w_data = 32'h0, rd, rdata, hi;
    logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] pins, pin_out, pin_oe, irq;
    logic [3:0] step_src = 4'h0;
    int errors = 0, checks = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    cam_pin_model cam_pin_model_inst (.ref_clk_i(ref_clk_i), .level_i(pin_req), .pin_o(pins));
    cam_counter_array cam_counter_array_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(w_data), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w_valid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(b_ready),
        .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(r_ready),
        .module_pin_i(pins), .module_pin_o(pin_out), .module_pin_oe_o(pin_oe), .module_irq_o(irq),
        .timer_zero_overflow_i(step_src[0]), .timer_one_overflow_i(step_src[1]),
        .timer_three_overflow_i(step_src[2]), .serial_zero_baud_overflow_i(step_src[3]));
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // bus write: address and data offered together, held until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        aw_addr <= a;
        w_data <= d;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        do @(posedge ref_clk_i); while (awready !== 1'b1);
        aw_valid <= 1'b0;
        w_valid <= 1'b0;
        while (bvalid !== 1'b1) @(posedge ref_clk_i);
        resp = bresp;
        b_ready <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    // bus read: data taken at the edge where rvalid is seen
    task automatic rd_reg(input logic [7:0] a);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        do @(posedge ref_clk_i); while (arready !== 1'b1);
        ar_valid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge ref_clk_i);
        rd = rdata;
        resp = rresp;
        r_ready <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    // reset values, step select field, unmapped place, module 6 capture bit
    task automatic t_regs();
        rd_reg(cam_pkg::OFF_AUX9);
        check(rd, 32'h0, "aux9 reset");
        wr(cam_pkg::OFF_AUX9, 32'h0000000C);
        rd_reg(cam_pkg::OFF_AUX9);
        check(rd, 32'h0000000C, "step select");
        rd_reg(8'hFC);
        check({30'h0, resp}, {30'h0, cam_pkg::RESP_SLVERR}, "unmapped");
        wr(8'h60, 32'h00000020);
        rd_reg(8'h60);
        check(rd, 32'h0, "module 6 rise");
    endtask
    // rising capture sets flag and irq; software clears; falling ignored
    task automatic t_capture();
        wr(cam_pkg::OFF_PAIR, 32'h00000001);
        wr(8'h00, 32'h00000021);
        pin_req <= 8'h01;
        repeat (8) @(posedge ref_clk_i);
        rd_reg(cam_pkg::OFF_FLAGS);
        check(rd, 32'h1, "capture flag");
        check({31'h0, irq[0]}, 32'h1, "irq");
        wr(cam_pkg::OFF_FLAGS, 32'h000000FE);
        rd_reg(cam_pkg::OFF_FLAGS);
        check(rd, 32'h0, "flag cleared");
        check({31'h0, irq[0]}, 32'h0, "irq cleared");
        pin_req <= 8'h00;
        repeat (8) @(posedge ref_clk_i);
        rd_reg(cam_pkg::OFF_FLAGS);
        check(rd, 32'h0, "fall ignored");
    endtask
    // software timer on module 1 and fast toggle on module 3, match 300 counts ahead
    task automatic t_timer();
        logic [15:0] t;
        rd_reg(cam_pkg::OFF_COUNT);
        t = rd[15:0] + 16'h012C;
        wr(8'h14, {24'h0, t[7:0]});
        wr(8'h18, {24'h0, t[15:8]});
        wr(8'h34, {24'h0, t[7:0]});
        wr(8'h38, {24'h0, t[15:8]});
        wr(8'h10, 32'h00000048);
        wr(8'h30, 32'h0000004C);
        repeat (400) @(posedge ref_clk_i);
        rd_reg(cam_pkg::OFF_FLAGS);
        check(rd, 32'hA, "timer flag");
        check({31'h0, pin_out[3]}, 32'h1, "fast output toggled");
    endtask
    // fifo chain on modules 0/1: only the selected step source moves it
    task automatic t_fifo();
        wr(8'h08, 32'h00000011);
        wr(8'h14, 32'h00000022);
        wr(8'h18, 32'h00000033);
        wr(8'h00, 32'h00000052);
        step_src <= 4'h1;
        @(posedge ref_clk_i);
        step_src <= 4'h8;
        @(posedge ref_clk_i);
        step_src <= 4'h0;
        rd_reg(8'h08);
        check(rd, 32'h22, "fifo high 0");
        rd_reg(8'h14);
        check(rd, 32'h33, "fifo low 1");
        rd_reg(8'h18);
        check(rd, 32'h11, "fifo high 1");
    endtask
    // buffered pair 0/1 compare output: start at 0x40, end at 0xC0
    task automatic t_compare_on_pwm_match();
        wr(8'h08, 32'h00000040);
        wr(8'h18, 32'h000000C0);
        wr(8'h10, 32'h00000046);
        wr(8'h00, 32'h00000046);
        repeat (300) @(posedge ref_clk_i);
        hi = 32'h0;
        repeat (512) begin
            @(posedge ref_clk_i);
            hi = hi + {31'h0, pin_out[0]};
        end
        check(hi, 32'h100, "pair pulse width");
    endtask
    // 8-bit pwm on module 2: high cycles in two full periods
    task automatic t_pwm();
        logic [8:0] tbl [4] = '{9'h000, 9'h040, 9'h0C0, 9'h100};
        wr(8'h20, 32'h00000042);
        foreach (tbl[i]) begin
            wr(8'h28, {24'h0, tbl[i][7:0]});
            wr(8'h2C, {30'h0, tbl[i][8], 1'b0});
            repeat (300) @(posedge ref_clk_i);
            hi = 32'h0;
            repeat (512) begin
                @(posedge ref_clk_i);
                hi = hi + {31'h0, pin_out[2]};
            end
            check(hi, (32'd256 - {23'h0, tbl[i]}) * 2, "pwm duty");
            check({31'h0, pin_oe[2]}, 32'h1, "pwm drive");
        end
    endtask
    initial begin
        repeat (16) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        @(posedge ref_clk_i);
        t_regs();
        t_capture();
        t_timer();
        t_pwm();
        t_fifo();
        t_compare_on_pwm_match();
        summarize();
    end
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        errors++;
        summarize();
    end
endmodule
